// *** rtl/sra_ctrl.sv ***
// host controller driving a 1K x 2 static ram array through its pins
// What this block does
// - all four active-low selects low to access
// - read/write select high reads, low writes
// - read gate low only during reads
// - write drives address, data, rw low, gate high
// - write timing low except at write end
// - allow 150 ns write cycle before next access
// - ten binary address lines for two-bit words
`timescale 1ns/1ps
`default_nettype none
`include "sra_defs.svh"
module sra_ctrl (
  input wire logic clk,
  input wire logic rst,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic [`SRA_ADDR_W-1:0] reqAddr,
  input wire logic [`SRA_DATA_W-1:0] reqWdata,
  input wire logic [`SRA_DATA_W-1:0] arrayDataOut,
  output logic reqReady,
  output logic rspValid,
  output logic [`SRA_DATA_W-1:0] rspRdata,
  output logic [`SRA_ADDR_W-1:0] arrayAddr,
  output logic [`SRA_DATA_W-1:0] arrayDataIn,
  output logic readWriteSel,
  output logic readGate_n,
  output logic write_timing_control,
  output logic array_select_n_0,
  output logic array_select_n_1,
  output logic array_select_n_2,
  output logic array_select_n_3
);
  localparam logic [`SRA_CNT_W-1:0] READ_CNT =
    `SRA_CNT_W'(`SRA_READ_CYCLES);
  localparam logic [`SRA_CNT_W-1:0] WRITE_CNT =
    `SRA_CNT_W'(`SRA_WRITE_CYCLES);

  // ===========================================================
  // state
  typedef struct packed {
    sra_pkg::sra_state_e state;
    logic [`SRA_CNT_W-1:0] cnt;
    logic ready;
    logic rspV;
    logic [`SRA_DATA_W-1:0] rdata;
    logic [`SRA_ADDR_W-1:0] addr;
    logic [`SRA_DATA_W-1:0] wdata;
    logic rw;
    logic gateN;
    logic wtc;
    logic selN;
  } sra_ctrl_s;

  sra_ctrl_s st_ff;
  sra_ctrl_s nxt_st;
  logic [`SRA_DATA_W-1:0] dataSync;

  // array output crosses in from outside the clock domain
  sra_sync uSync (
    .clk(clk),
    .rst(rst),
    .asyncIn(arrayDataOut),
    .syncOut(dataSync)
  );

  // ===========================================================
  // access sequencer
  always_comb begin
    nxt_st = st_ff;
    nxt_st.rspV = 1'b0;
    unique case (st_ff.state)
      sra_pkg::SRA_IDLE: begin
        nxt_st.wtc = 1'b0;
        nxt_st.gateN = 1'b1;
        if (reqValid && st_ff.ready) begin
          nxt_st.ready = 1'b0;
          nxt_st.addr = reqAddr;
          nxt_st.wdata = reqWdata;
          nxt_st.selN = 1'b0;
          if (reqWrite) begin
            nxt_st.state = sra_pkg::SRA_WRITE;
            nxt_st.rw = 1'b0;
            nxt_st.gateN = 1'b1;
            nxt_st.cnt = WRITE_CNT - `SRA_CNT_W'(1);
          end else begin
            nxt_st.state = sra_pkg::SRA_READ;
            nxt_st.rw = 1'b1;
            nxt_st.gateN = 1'b0;
            // access time, one cycle to spare, then two sync stages
            nxt_st.cnt = READ_CNT + `SRA_CNT_W'(2);
          end
        end
      end
      sra_pkg::SRA_READ: begin
        // pins held steady until the cycle ends
        nxt_st.cnt = st_ff.cnt - `SRA_CNT_W'(1);
        if (st_ff.cnt == `SRA_CNT_W'(0)) begin
          nxt_st.rdata = dataSync;
          nxt_st.rspV = 1'b1;
          nxt_st.gateN = 1'b1;
          nxt_st.selN = 1'b1;
          nxt_st.rw = 1'b1;
          nxt_st.ready = 1'b1;
          nxt_st.state = sra_pkg::SRA_IDLE;
        end
      end
      sra_pkg::SRA_WRITE: begin
        nxt_st.cnt = st_ff.cnt - `SRA_CNT_W'(1);
        // release timing control in the final cycle of the write
        nxt_st.wtc = (st_ff.cnt == `SRA_CNT_W'(1));
        if (st_ff.cnt == `SRA_CNT_W'(0)) begin
          nxt_st.wtc = 1'b0;
          nxt_st.selN = 1'b1;
          nxt_st.rw = 1'b1;
          nxt_st.rspV = 1'b1;
          nxt_st.ready = 1'b1;
          nxt_st.state = sra_pkg::SRA_IDLE;
        end
      end
      default: begin
        nxt_st.state = sra_pkg::SRA_IDLE;
        nxt_st.ready = 1'b1;
      end
    endcase
  end

  // ===========================================================
  // registers
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= '{state: sra_pkg::SRA_IDLE, cnt: '0, ready: 1'b1,
                 rspV: 1'b0, rdata: '0, addr: '0, wdata: '0,
                 rw: 1'b1, gateN: 1'b1, wtc: 1'b0, selN: 1'b1};
    end else begin
      st_ff <= nxt_st;
    end
  end

  // pin and port outputs straight from flip-flops
  assign reqReady = st_ff.ready;
  assign rspValid = st_ff.rspV;
  assign rspRdata = st_ff.rdata;
  assign arrayAddr = st_ff.addr;
  assign arrayDataIn = st_ff.wdata;
  assign readWriteSel = st_ff.rw;
  assign readGate_n = st_ff.gateN;
  assign write_timing_control = st_ff.wtc;
  assign array_select_n_0 = st_ff.selN;
  assign array_select_n_1 = st_ff.selN;
  assign array_select_n_2 = st_ff.selN;
  assign array_select_n_3 = st_ff.selN;

  // ===========================================================
  // checks
  // a request taken from idle into each kind of access
  sequence writeStart_q;
    st_ff.state == sra_pkg::SRA_IDLE && nxt_st.state == sra_pkg::SRA_WRITE;
  endsequence
  sequence readStart_q;
    st_ff.state == sra_pkg::SRA_IDLE && nxt_st.state == sra_pkg::SRA_READ;
  endsequence
  // write pins hold thirty cycles, then the select goes back to read
  sequence writeHeld_q;
    (!readWriteSel && !array_select_n_0)[*8] ##22 !readWriteSel
      ##1 readWriteSel;
  endsequence
  // timing control stays low until one pulse in the last write cycle
  sequence wtcPulse_q;
    (!write_timing_control)[*8] ##21 !write_timing_control
      ##1 write_timing_control ##1 !write_timing_control;
  endsequence
  // read gate holds low until the data has been taken
  sequence gateHeld_q;
    (!readGate_n)[*8] ##20 !readGate_n ##1 readGate_n;
  endsequence
  // no response before the access time and both sync stages
  sequence readWait_q;
    (!rspValid)[*8] ##20 !rspValid ##1 rspValid;
  endsequence

  gate_in_write_a: assert property (@(posedge clk)
    disable iff (rst) !readWriteSel |-> readGate_n)
    else $error("read gate low during write");
  wtc_only_write_a: assert property (@(posedge clk)
    disable iff (rst)
    write_timing_control |-> !readWriteSel && !array_select_n_0)
    else $error("timing control high outside write");
  write_length_a: assert property (@(posedge clk)
    disable iff (rst) writeStart_q |=> writeHeld_q)
    else $error("write cycle length wrong");
  wtc_end_a: assert property (@(posedge clk)
    disable iff (rst) writeStart_q |=> wtcPulse_q)
    else $error("timing control not released at write end");
  read_gate_a: assert property (@(posedge clk)
    disable iff (rst) !readGate_n |-> readWriteSel && !array_select_n_3)
    else $error("read gate without read select");
  gate_hold_a: assert property (@(posedge clk)
    disable iff (rst) readStart_q |=> gateHeld_q)
    else $error("read gate length wrong");
  sel_tied_a: assert property (@(posedge clk)
    disable iff (rst)
    array_select_n_0 == array_select_n_1 &&
    array_select_n_2 == array_select_n_3 &&
    array_select_n_0 == array_select_n_2)
    else $error("array selects differ");
  addr_stable_a: assert property (@(posedge clk)
    disable iff (rst) !array_select_n_0 && !$past(array_select_n_0) |->
    $stable(arrayAddr) && $stable(arrayDataIn))
    else $error("address moved during access");
  read_wait_a: assert property (@(posedge clk)
    disable iff (rst) $fell(readGate_n) |-> readWait_q)
    else $error("read response timing wrong");
  idle_quiet_a: assert property (@(posedge clk)
    disable iff (rst)
    reqReady |-> array_select_n_0 && readGate_n && !write_timing_control)
    else $error("array pins active while idle");
  rsp_pulse_a: assert property (@(posedge clk)
    disable iff (rst) rspValid |=> !rspValid)
    else $error("response longer than one cycle");
endmodule
`default_nettype wire

// *** common/sra_defs.svh ***
// timing counts and bus widths for the static ram array controller
`ifndef SRA_DEFS_SVH
`define SRA_DEFS_SVH
`define SRA_CLK_PERIOD_NS 5
`define SRA_READ_ACCESS_NS 125
`define SRA_WRITE_CYCLE_NS 150
// least times round up to whole cycles
`define SRA_READ_CYCLES \
  ((`SRA_READ_ACCESS_NS + `SRA_CLK_PERIOD_NS - 1) / `SRA_CLK_PERIOD_NS)
`define SRA_WRITE_CYCLES \
  ((`SRA_WRITE_CYCLE_NS + `SRA_CLK_PERIOD_NS - 1) / `SRA_CLK_PERIOD_NS)
`define SRA_ADDR_W 10
`define SRA_DATA_W 2
`define SRA_CNT_W 6
`endif

// *** common/sra_pkg.sv ***
// types for the static ram array controller
package sra_pkg;
  typedef enum logic [2:0] {
    SRA_IDLE  = 3'b001,
    SRA_READ  = 3'b010,
    SRA_WRITE = 3'b100
  } sra_state_e;
endpackage

// *** rtl/sra_sync.sv ***
// two flip-flop synchroniser for the array data outputs
`timescale 1ns/1ps
`default_nettype none
`include "sra_defs.svh"
module sra_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic [`SRA_DATA_W-1:0] asyncIn,
  output logic [`SRA_DATA_W-1:0] syncOut
);
  typedef struct packed {
    logic [`SRA_DATA_W-1:0] stage1;
    logic [`SRA_DATA_W-1:0] stage2;
  } sra_sync_s;
  sra_sync_s st_ff;
  sra_sync_s nxt_st;
  // first stage feeds only the second; idle array output is high
  always_comb begin
    nxt_st = st_ff;
    nxt_st.stage1 = asyncIn;
    nxt_st.stage2 = st_ff.stage1;
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      st_ff <= {2{2'h3}};
    end else begin
      st_ff <= nxt_st;
    end
  end
  assign syncOut = st_ff.stage2;
endmodule
`default_nettype wire

// *** tb/sra_array_model.sv ***
// behavioural 1K x 2 static array standing at the controller's pins
`timescale 1ns/1ps
`default_nettype none
module sra_array_model (
  input wire logic [9:0] addr,
  input wire logic [1:0] dataIn,
  input wire logic rwSel,
  input wire logic gate_n,
  input wire logic wtc,
  input wire logic [3:0] sel_n,
  output logic [1:0] dataOut
);
  logic [1:0] mem [0:1023];
  logic selected;
  logic [10:0] key;
  logic [10:0] keyLate;
  // selected only while all four selects are low
  assign selected = (sel_n == 4'h0);
  // write lands when timing control is released, only if selected
  always @(posedge wtc) begin
    if (selected && !rwSel) begin
      mem[addr] <= dataIn;
    end
  end
  // a read counts its access time from its last address or gate change
  assign key = {selected && !gate_n && rwSel, addr};
  always @(key) begin
    keyLate <= #125 key;
  end
  // open collector output pulled high unless a read has settled
  assign dataOut = (key[10] && keyLate === key) ?
    mem[addr] : 2'h3;
endmodule
`default_nettype wire

// *** tb/sra_ctrl_tb.sv ***
// self-checking bench for the static ram array controller
`timescale 1ns/1ps
`default_nettype none
module sra_ctrl_tb;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic [9:0] reqAddr = 10'h000;
  logic [1:0] reqWdata = 2'h0;
  logic reqReady, rspValid, rwSel, gate_n, wtc;
  logic [1:0] rspRdata, dIn, dOut;
  logic [9:0] aOut;
  logic [3:0] sel_n;
  int errors = 0;
  int n_compared = 0;
  // ==========================================
  // clock, design and array
  always #2.5 clk = ~clk;
  sra_ctrl i_dut (.clk(clk), .rst(rst), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
    .arrayDataOut(dOut), .reqReady(reqReady), .rspValid(rspValid),
    .rspRdata(rspRdata), .arrayAddr(aOut), .arrayDataIn(dIn),
    .readWriteSel(rwSel), .readGate_n(gate_n),
    .write_timing_control(wtc), .array_select_n_0(sel_n[0]),
    .array_select_n_1(sel_n[1]), .array_select_n_2(sel_n[2]),
    .array_select_n_3(sel_n[3]));
  sra_array_model i_mem (.addr(aOut), .dataIn(dIn), .rwSel(rwSel),
    .gate_n(gate_n), .wtc(wtc), .sel_n(sel_n), .dataOut(dOut));
  // ==========================================
  // comparison and closing report
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // ==========================================
  // one access, counting pin activity until the response
  task automatic access(input logic wr, input logic [9:0] a,
      input logic [1:0] d, output logic [1:0] q);
    int lat, nWtc, nGate, nRw, nSel, nMoved, nRdy;
    lat = 0;
    nRdy = 0;
    nWtc = 0;
    nGate = 0;
    nRw = 0;
    nSel = 0;
    nMoved = 0;
    reqWrite = wr;
    reqAddr = a;
    reqWdata = d;
    reqValid = 1'b1;
    @(posedge clk);
    #1 reqValid = 1'b0;
    while (rspValid !== 1'b1 && lat < 40) begin
      nWtc += (wtc === 1'b1);
      nGate += (gate_n === 1'b0);
      nRw += (rwSel === 1'b0);
      nSel += (sel_n === 4'h0);
      nMoved += (sel_n === 4'h0 && (aOut !== a || (wr && dIn !== d)));
      nRdy += (reqReady !== 1'b0);
      lat++;
      @(posedge clk);
      #1;
    end
    q = rspRdata;
    check(16'(lat), wr ? 16'h001E : 16'h001C);
    check(16'(nWtc), 16'(wr));
    check(16'(nGate), wr ? 16'h0000 : 16'h001C);
    check(16'(nRw), wr ? 16'h001E : 16'h0000);
    check(16'(nSel), wr ? 16'h001E : 16'h001C);
    check(16'(nMoved), 16'h0000);
    check(16'(nRdy), 16'h0000);
    check({15'h0000, reqReady}, 16'h0001);
    if (lat >= 40) begin
      end_of_test();
    end
  endtask
  // idle pins: deselected, read level, gate high, timing control low
  task automatic idle_pins;
    check({12'h000, sel_n}, 16'h000F);
    check({14'h0000, rwSel, gate_n}, 16'h0003);
    check({15'h0000, wtc}, 16'h0000);
    check({14'h0000, dOut}, 16'h0003);
  endtask
  // back-to-back writes at the end and alternating-bit addresses, then read back
  task automatic write_read;
    logic [9:0] addrs [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
    logic [1:0] q;
    for (int i = 0; i < 4; i++) begin
      access(1'b1, addrs[i], 2'(i), q);
    end
    for (int i = 0; i < 4; i++) begin
      access(1'b0, addrs[i], 2'h0, q);
      check(16'(q), 16'(i));
    end
  endtask
  // reset in mid-write: pins fall idle and the cut write never lands
  task automatic reset_mid_write;
    logic [1:0] q;
    reqWrite = 1'b1;
    reqAddr = 10'h155;
    reqWdata = 2'h1;
    reqValid = 1'b1;
    @(posedge clk);
    #1 reqValid = 1'b0;
    repeat (10) @(posedge clk);
    #1 rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    idle_pins();
    access(1'b0, 10'h155, 2'h0, q);
    check(16'(q), 16'h0002);
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    idle_pins();
    write_read();
    reset_mid_write();
    idle_pins();
    end_of_test();
  end
endmodule
`default_nettype wire
